// File: logic/mdsp_pkg.sv
package mdsp_pkg;

  // frame lengths in serial clocks, then code and channel widths and the register word count
  localparam int unsigned ADDR_WORD_BITS = 10;
  localparam int unsigned DAC_FRAME_BITS = 24;
  localparam int unsigned READ_BITS      = 14;
  localparam int unsigned CODE_W         = 14;
  localparam int unsigned CHAN_W         = 6;
  localparam int unsigned NUM_WORDS      = 33;

  localparam logic [4:0] CNT_ADDR_END = 5'h0a;
  localparam logic [4:0] CNT_DAC_END  = 5'h18;
  localparam logic [4:0] CNT_READ_END = 5'h0e;

  // mode field values
  localparam logic [1:0] MODE_ACQ      = 2'h0;
  localparam logic [1:0] MODE_DAC      = 2'h1;
  localparam logic [1:0] MODE_ACQ_READ = 2'h2;
  localparam logic [1:0] MODE_READ     = 2'h3;

  // bit positions inside the 10-bit addressing word, msb first on the wire
  localparam int unsigned POS_MODE_HI = 9;
  localparam int unsigned POS_MODE_LO = 8;
  localparam int unsigned POS_CAL     = 7;
  localparam int unsigned POS_OFFS    = 6;
  localparam int unsigned POS_TEST    = 5;
  localparam int unsigned POS_ADDR_HI = 4;
  localparam int unsigned POS_ADDR_LO = 0;

  localparam logic [5:0] OFFSET_CHAN = 6'h20;

  // reset values
  localparam logic [13:0] CODE_RESET = 14'h0000;
  localparam logic [23:0] SHIFT_RESET = 24'h000000;
  // idle pin levels: strap, fsel, sclk, din, wr, addr[4:0], offs, cal
  localparam logic [11:0] PIN_IDLE    = 12'hc80;

  // acquisition timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned ACQ_ONE_US    = 16;
  localparam int unsigned ACQ_ALL_US    = 45;
  localparam int unsigned ACQ_ONE_CYC   = ACQ_ONE_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned ACQ_ALL_CYC   = ACQ_ALL_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned BUSY_W        = 16;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SHIFT_IN,
    ST_READ_OUT,
    ST_DONE
  } mdsp_state_e;

endpackage

// File: logic/mdsp_regfile.sv
`timescale 1ns/1ps
module mdsp_regfile
  import mdsp_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              wr_en,
  input  wire logic [CHAN_W-1:0] wr_addr,
  input  wire logic [CODE_W-1:0] wr_data,
  input  wire logic              fill_en,
  input  wire logic [CODE_W-1:0] fill_data,
  input  wire logic [CHAN_W-1:0] rd_addr,
  output logic      [CODE_W-1:0] rd_data
);

  logic [CODE_W-1:0] mem_ff [NUM_WORDS];

  // fill wins over a single write: it covers every word anyway
  always_ff @(posedge clock)
  begin
    for (int i = 0; i < NUM_WORDS; i++)
    begin
      if (fill_en)
        mem_ff[i] <= fill_data;
      else if (wr_en && (wr_addr == CHAN_W'(i)))
        mem_ff[i] <= wr_data;
    end
  end

  wire rd_hit = (rd_addr < CHAN_W'(NUM_WORDS));

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      rd_data <= CODE_RESET;
    else
      rd_data <= rd_hit ? mem_ff[rd_addr] : CODE_RESET;
  end

endmodule

// File: logic/mdsp_port.sv
// Design decisions made here: the register offsets and the strobed register port.
`timescale 1ns/1ps
module mdsp_port
  import mdsp_pkg::*;
#(
  parameter logic        CAL_FILL_ONES = 1'b0,
  parameter int unsigned ACQ_ALL_CYCLES = ACQ_ALL_CYC
)
(
  input  wire logic              clock,
  input  wire logic              reset,
  input  wire logic              interface_select_strap,
  input  wire logic              frame_sel_n,
  input  wire logic              sclk,
  input  wire logic              din,
  output logic                   dout,
  output logic                   dout_oe,
  input  wire logic              wr_n,
  input  wire logic [4:0]        channel_addr,
  input  wire logic              offset_sel,
  input  wire logic              cal,
  input  wire logic              acq_result_valid,
  input  wire logic [CHAN_W-1:0] acq_result_chan,
  input  wire logic [CODE_W-1:0] acq_result_code,
  output logic                   acquire_mode,
  output logic                   acq_start,
  output logic [CHAN_W-1:0]      acq_chan,
  output logic                   acq_all,
  output logic                   acq_busy,
  output logic                   dac_load,
  output logic [CHAN_W-1:0]      dac_chan,
  output logic [CODE_W-1:0]      dac_code
);

  function automatic logic [CHAN_W-1:0] chan_sel(input logic offs,
                                                 input logic [4:0] addr);
    chan_sel = offs ? OFFSET_CHAN : {1'b0, addr};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: stage one feeds stage two only

  localparam int unsigned NSYNC = 12;

  logic [NSYNC-1:0] sync1_ff;
  logic [NSYNC-1:0] sync2_ff;
  logic [NSYNC-1:0] pins_w;

  assign pins_w = {interface_select_strap, frame_sel_n, sclk, din, wr_n,
                   channel_addr, offset_sel, cal};

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      // idle levels, so that no false edge follows reset
      sync1_ff <= PIN_IDLE;
      sync2_ff <= PIN_IDLE;
    end
    else
    begin
      sync1_ff <= pins_w;
      sync2_ff <= sync1_ff;
    end
  end

  wire       strap_s = sync2_ff[11];
  wire       fsel_s  = sync2_ff[10];
  wire       sclk_s  = sync2_ff[9];
  wire       din_s   = sync2_ff[8];
  wire       wr_s    = sync2_ff[7];
  wire [4:0] addr_s  = sync2_ff[6:2];
  wire       offs_s  = sync2_ff[1];
  wire       cal_s   = sync2_ff[0];

  // edge detection looks only at the second stage and a delayed copy
  logic fsel_d_ff;
  logic sclk_d_ff;
  logic wr_d_ff;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      fsel_d_ff <= 1'b1;
      sclk_d_ff <= 1'b0;
      wr_d_ff   <= 1'b1;
    end
    else
    begin
      fsel_d_ff <= fsel_s;
      sclk_d_ff <= sclk_s;
      wr_d_ff   <= wr_s;
    end
  end

  wire serial_en  = strap_s;
  wire fsel_fall  = fsel_d_ff & ~fsel_s;
  wire sclk_rise  = ~sclk_d_ff & sclk_s;
  wire sclk_fall  = sclk_d_ff & ~sclk_s;
  wire wr_rise    = ~wr_d_ff & wr_s;
  wire cs_active  = ~fsel_s;

  assign acquire_mode = ~strap_s;

  ////////////////////////////////////////////////////////////////////////////
  // serial frame control

  mdsp_state_e       state_ff;
  mdsp_state_e       nxt_state;
  logic [4:0]        cnt_ff;
  logic [23:0]       shift_in_ff;
  logic [CODE_W-1:0] shift_out_ff;
  logic              rb_pending_ff;
  logic [CHAN_W-1:0] rb_chan_ff;
  logic [CODE_W-1:0] rd_data;

  wire in_frame   = (state_ff == ST_SHIFT_IN) || (state_ff == ST_READ_OUT);
  wire start      = serial_en && fsel_fall && !in_frame;
  wire [23:0] nxt_shift = {shift_in_ff[22:0], din_s};
  wire [4:0]  nxt_cnt   = cnt_ff + 5'h01;

  wire [1:0] mode_w  = {nxt_shift[POS_MODE_HI], nxt_shift[POS_MODE_LO]};
  wire [1:0] mode_24 = {nxt_shift[POS_MODE_HI + READ_BITS],
                        nxt_shift[POS_MODE_LO + READ_BITS]};
  wire in_fall    = (state_ff == ST_SHIFT_IN) && sclk_fall;
  wire end_addr   = in_fall && (nxt_cnt == CNT_ADDR_END)
                    && (mode_w != MODE_DAC);
  wire end_dac    = in_fall && (nxt_cnt == CNT_DAC_END)
                    && (mode_24 == MODE_DAC);

  wire [9:0] word10 = nxt_shift[9:0];
  wire [9:0] word24 = nxt_shift[23:14];
  wire [CHAN_W-1:0] ser_chan = chan_sel(word10[POS_OFFS],
                               word10[POS_ADDR_HI:POS_ADDR_LO]);
  wire [CHAN_W-1:0] dac_chan_w = chan_sel(word24[POS_OFFS],
                                 word24[POS_ADDR_HI:POS_ADDR_LO]);
  wire ser_acq   = end_addr && !mode_w[0];
  wire ser_rb    = end_addr && mode_w[1];
  wire dac_fill  = end_dac && word24[POS_CAL];
  wire dac_wr    = end_dac && !word24[POS_CAL];
  // the test bit is not decoded: it only matters for factory test

  wire rd_fall   = (state_ff == ST_READ_OUT) && sclk_fall && dout_oe;
  wire rd_end    = rd_fall && (nxt_cnt == CNT_READ_END);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE, ST_DONE:
        if (start)
          nxt_state = rb_pending_ff ? ST_READ_OUT : ST_SHIFT_IN;
      ST_SHIFT_IN:
        if (end_addr || end_dac)
          nxt_state = ST_DONE;
      ST_READ_OUT:
        if (rd_end)
          nxt_state = ST_DONE;
      default:
        nxt_state = ST_IDLE;
    endcase
    if (!serial_en)
      nxt_state = ST_IDLE;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // counter cleared only by the first frame-select fall of a frame
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      cnt_ff <= 5'h00;
    else if (start)
      cnt_ff <= 5'h00;
    else if (in_fall || rd_fall)
      cnt_ff <= nxt_cnt;
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      shift_in_ff <= SHIFT_RESET;
    else if (start)
      shift_in_ff <= SHIFT_RESET;
    else if (in_fall)
      shift_in_ff <= nxt_shift;
  end

  // a readback frame always follows an addressing write in a read mode
  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      rb_pending_ff <= 1'b0;
      rb_chan_ff    <= 6'h00;
    end
    else if (ser_rb)
    begin
      rb_pending_ff <= 1'b1;
      rb_chan_ff    <= ser_chan;
    end
    else if (start || !serial_en)
      rb_pending_ff <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // readback shifter; din is not looked at in this state

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      shift_out_ff <= CODE_RESET;
      dout         <= 1'b0;
      dout_oe      <= 1'b0;
    end
    else if (start)
    begin
      shift_out_ff <= rd_data;
      dout_oe      <= 1'b0;
    end
    else if ((state_ff == ST_READ_OUT) && sclk_rise)
    begin
      dout         <= shift_out_ff[CODE_W-1];
      shift_out_ff <= {shift_out_ff[CODE_W-2:0], 1'b0};
      dout_oe      <= 1'b1;
    end
    else if (rd_end || !serial_en)
      dout_oe      <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // parallel port, acquire only

  wire par_acq = !serial_en && cs_active && wr_rise;

  ////////////////////////////////////////////////////////////////////////////
  // outputs toward the analog side

  wire any_acq  = ser_acq || par_acq;
  wire all_w    = serial_en ? word10[POS_CAL] : cal_s;
  wire [CHAN_W-1:0] acq_chan_w = serial_en ? ser_chan
                                 : chan_sel(offs_s, addr_s);

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      acq_start <= 1'b0;
      acq_chan  <= 6'h00;
      acq_all   <= 1'b0;
    end
    else
    begin
      acq_start <= any_acq;
      if (any_acq)
      begin
        acq_chan <= acq_chan_w;
        acq_all  <= all_w;
      end
    end
  end

  // busy covers the one- or all-channel acquisition time; the all-channel time is typical
  logic [BUSY_W-1:0] busy_ff;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      busy_ff <= 16'h0000;
    else if (any_acq)
      busy_ff <= all_w ? BUSY_W'(ACQ_ALL_CYCLES) : BUSY_W'(ACQ_ONE_CYC);
    else if (busy_ff != 16'h0000)
      busy_ff <= busy_ff - 16'h0001;
  end

  assign acq_busy = (busy_ff != 16'h0000);

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      dac_load <= 1'b0;
      dac_chan <= 6'h00;
      dac_code <= CODE_RESET;
    end
    else
    begin
      dac_load <= dac_wr;
      if (dac_wr)
      begin
        dac_chan <= dac_chan_w;
        dac_code <= nxt_shift[CODE_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register store; serial load has priority over an acquisition result

  wire [CODE_W-1:0] fill_w = {CODE_W{CAL_FILL_ONES}};
  wire              mem_we = dac_wr || acq_result_valid;
  wire [CHAN_W-1:0] mem_wa = dac_wr ? dac_chan_w : acq_result_chan;
  wire [CODE_W-1:0] mem_wd = dac_wr ? nxt_shift[CODE_W-1:0]
                                    : acq_result_code;

  mdsp_regfile u_regfile (
    .clock     (clock),
    .reset     (reset),
    .wr_en     (mem_we),
    .wr_addr   (mem_wa),
    .wr_data   (mem_wd),
    .fill_en   (dac_fill),
    .fill_data (fill_w),
    .rd_addr   (rb_chan_ff),
    .rd_data   (rd_data)
  );

endmodule

// File: test/mdsp_port_props.sv
`timescale 1ns/1ps
module mdsp_port_props
  import mdsp_pkg::*;
#(
  parameter int unsigned ACQ_ALL_CYCLES = ACQ_ALL_CYC
)
(
  input wire logic              clock,
  input wire logic              reset,
  input wire logic              frame_sel_n,
  input wire logic              sclk,
  input wire logic              dout_oe,
  input wire logic [4:0]        channel_addr,
  input wire logic              offset_sel,
  input wire logic              cal,
  input wire logic              acquire_mode,
  input wire logic              acq_start,
  input wire logic [CHAN_W-1:0] acq_chan,
  input wire logic              acq_all,
  input wire logic              acq_busy,
  input wire logic              dac_load
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // cycles that busy has stood since the last acquire start
  int busy_len;

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
      busy_len <= 0;
    else if (acq_start)
      busy_len <= 1;
    else if (acq_busy)
      busy_len <= busy_len + 1;
  end
////////////////////////////////////////////////////////////////////////////
  start_pulse_a: assert property (acq_start |=> !acq_start)
    else $error("acquire start longer than one cycle");
  busy_follow_a: assert property (acq_start |-> ##[0:1] acq_busy)
    else $error("busy missing after acquire start");
  busy_len_a: assert property ($fell(acq_busy) |->
    busy_len == (acq_all ? ACQ_ALL_CYCLES : ACQ_ONE_CYC))
    else $error("acquisition busy time wrong");
  load_pulse_a: assert property (dac_load |=> !dac_load)
    else $error("dac load longer than one cycle");
  par_quiet_a: assert property (
    acquire_mode |-> !dac_load && !dout_oe)
    else $error("serial activity in parallel mode");
  par_offs_a: assert property (
    acq_start && acquire_mode && offset_sel |-> acq_chan == OFFSET_CHAN)
    else $error("offset pin ignored");
  par_addr_a: assert property (
    acq_start && acquire_mode && !offset_sel |->
    acq_chan == {1'b0, channel_addr})
    else $error("wrong parallel channel");
  par_cal_a: assert property (
    acq_start && acquire_mode |-> acq_all == cal)
    else $error("cal pin not followed");
  // the host holds frame select low through the read frame
  oe_on_rise_a: assert property (
    $rose(dout_oe) |-> sclk && !frame_sel_n)
    else $error("output enabled outside a clock high phase");
  oe_off_fall_a: assert property ($fell(dout_oe) |-> !sclk)
    else $error("output released outside a clock low phase");
endmodule

// File: test/mdsp_host_model.sv
`timescale 1ns/1ps
module mdsp_host
(
  output logic      frame_sel_n,
  output logic      sclk,
  output logic      din,
  input  wire logic dout,
  input  wire logic dout_oe
);
  // sclk rests low between pulses; the clocks task also pulses it outside frames
  initial
  begin
    frame_sel_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
////////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [23:0] w, input int n, input bit glitch);
    frame_sel_n = 1'b0;
    // quarter-ns offset keeps link edges off the system clock edges
    #100.25;
    for (int i = 0; i < n; i++)
    begin
      sclk = 1'b1;
      din = w[n-1-i];
      if (glitch && i == 4) frame_sel_n = 1'b1;
      #62.5;
      sclk = 1'b0;
      if (glitch && i == 4) frame_sel_n = 1'b0;
      #62.5;
    end
    din = ~din;
    #100;
    frame_sel_n = 1'b1;
    #500;
  endtask

  task automatic read(output logic [13:0] d, output logic oe_all);
    oe_all = 1'b1;
    frame_sel_n = 1'b0;
    #100.25;
    for (int i = 0; i < 14; i++)
    begin
      sclk = 1'b1;
      din = ~din;
      #62.5;
      // a released line reads as the inverse of the last driven bit
      d = {d[12:0], dout_oe ? dout : ~dout};
      oe_all = oe_all & dout_oe;
      sclk = 1'b0;
      #62.5;
    end
    #100;
    frame_sel_n = 1'b1;
    #500;
  endtask

  task automatic clocks(input int n);
    #0.25;
    repeat (n)
    begin
      sclk = 1'b1;
      #62.5;
      sclk = 1'b0;
      #62.5;
    end
  endtask

  task automatic select(input logic v);
    frame_sel_n = v;
  endtask
endmodule

// File: test/tb.sv
`timescale 1ns/1ps
module tb;
  import mdsp_pkg::*;
  localparam logic        FILL = 1'b1;
  localparam int unsigned ALLC = 50;
  logic                clock, reset, strap, wr_n, offset_sel, cal, res_valid;
  logic [4:0]          channel_addr;
  logic [CHAN_W-1:0]   res_chan;
  logic [CODE_W-1:0]   res_code;
  logic                oe_all;
  logic [13:0]         rd;
  wire logic           frame_sel_n, sclk, din, dout, dout_oe, acquire_mode;
  wire logic           acq_start, acq_all, acq_busy, dac_load;
  wire logic [CHAN_W-1:0] acq_chan, dac_chan;
  wire logic [CODE_W-1:0] dac_code;
  int                  fails, compares, cycles, n_acq, n_dac;

  mdsp_port #(.CAL_FILL_ONES(FILL), .ACQ_ALL_CYCLES(ALLC)) dut (
    .clock(clock), .reset(reset), .interface_select_strap(strap),
    .frame_sel_n(frame_sel_n), .sclk(sclk), .din(din), .dout(dout),
    .dout_oe(dout_oe), .wr_n(wr_n), .channel_addr(channel_addr),
    .offset_sel(offset_sel), .cal(cal), .acq_result_valid(res_valid),
    .acq_result_chan(res_chan), .acq_result_code(res_code),
    .acquire_mode(acquire_mode), .acq_start(acq_start), .acq_chan(acq_chan),
    .acq_all(acq_all), .acq_busy(acq_busy), .dac_load(dac_load),
    .dac_chan(dac_chan), .dac_code(dac_code));

  mdsp_host host (.frame_sel_n(frame_sel_n), .sclk(sclk), .din(din),
    .dout(dout), .dout_oe(dout_oe));

  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (acq_start === 1'b1) n_acq++;
    if (dac_load === 1'b1) n_dac++;
    // ceiling well above the roughly 14k cycles the tests need
    if (cycles == 60000)
    begin
      fails++;
      summarize;
    end
  end

  task check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp)
    begin
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      fails++;
    end
  endtask

  task done(input string n);
    $display("test %s done", n);
  endtask

  task wait_idle;
    int k;
    k = 0;
    while (acq_busy !== 1'b0 && k < 8000)
    begin
      @(posedge clock);
      k++;
    end
    if (acq_busy !== 1'b0)
    begin
      fails++;
      summarize;
    end
  endtask

  task dac_wr(input logic [4:0] a, input logic offs, input logic cb,
              input logic [13:0] code, input bit glitch);
    host.send({MODE_DAC, cb, offs, 1'b0, a, code}, 24, glitch);
    @(negedge clock);
  endtask

  task acq_wr(input logic [4:0] a, input logic cb);
    host.send({14'h0, MODE_ACQ, cb, 1'b0, 1'b0, a}, 10, 1'b0);
    @(negedge clock);
  endtask

  task readback(input logic [1:0] m, input logic [4:0] a, input logic offs,
                input logic [13:0] exp);
    host.send({14'h0, m, 1'b0, offs, 1'b0, a}, 10, 1'b0);
    wait_idle;
    host.read(rd, oe_all);
    @(negedge clock);
    check(rd, exp);
    check(oe_all, 1'b1);
    check(dout_oe, 1'b0);
  endtask

  task par_wr(input logic cs_n, input logic [4:0] a, input logic offs,
              input logic cb);
    host.select(cs_n);
    @(posedge clock);
    channel_addr <= a;
    offset_sel <= offs;
    cal <= cb;
    repeat (5) @(posedge clock);
    wr_n <= 1'b0;
    repeat (6) @(posedge clock);
    wr_n <= 1'b1;
    repeat (10) @(posedge clock);
    @(negedge clock);
    host.select(1'b1);
    wait_idle;
    @(negedge clock);
  endtask
////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset = 1'b1;
    strap = 1'b1;
    wr_n = 1'b1;
    channel_addr = 5'h00;
    offset_sel = 1'b0;
    cal = 1'b0;
    res_valid = 1'b0;
    res_chan = 6'h00;
    res_code = 14'h0000;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    repeat (4) @(negedge clock);
    check(acquire_mode, 1'b0);
    host.clocks(12);
    repeat (8) @(negedge clock);
    check(n_acq + n_dac, 0);
    dac_wr(5'h05, 1'b0, 1'b0, 14'h2a5c, 1'b0);
    check(n_dac, 1);
    check(dac_chan, 6'h05);
    check(dac_code, 14'h2a5c);
    readback(MODE_READ, 5'h05, 1'b0, 14'h2a5c);
    done("dac load");
    dac_wr(5'h1f, 1'b1, 1'b0, 14'h3fff, 1'b0);
    check(dac_chan, OFFSET_CHAN);
    readback(MODE_READ, 5'h00, 1'b1, 14'h3fff);
    done("offset");
    dac_wr(5'h02, 1'b0, 1'b0, 14'h1234, 1'b1);
    check(n_dac, 3);
    check(dac_code, 14'h1234);
    host.clocks(30);
    check(n_dac, 3);
    done("framing");
    dac_wr(5'h00, 1'b0, 1'b1, 14'h0000, 1'b0);
    check(n_dac, 3);
    readback(MODE_READ, 5'h07, 1'b0, {14{FILL}});
    done("cal fill");
    acq_wr(5'h1f, 1'b0);
    check(n_acq, 1);
    check({acq_all, acq_chan}, 7'h1f);
    wait_idle;
    acq_wr(5'h04, 1'b1);
    check(acq_all, 1'b1);
    wait_idle;
    @(posedge clock);
    res_valid <= 1'b1;
    res_chan <= 6'h09;
    res_code <= 14'h0abc;
    @(posedge clock);
    res_valid <= 1'b0;
    readback(MODE_ACQ_READ, 5'h09, 1'b0, 14'h0abc);
    check(n_acq, 3);
    done("acquire");
    @(posedge clock);
    strap <= 1'b0;
    repeat (6) @(negedge clock);
    check(acquire_mode, 1'b1);
    dac_wr(5'h01, 1'b0, 1'b0, 14'h0555, 1'b0);
    check(n_dac, 3);
    par_wr(1'b0, 5'h0a, 1'b0, 1'b0);
    check(acq_chan, 6'h0a);
    par_wr(1'b0, 5'h0a, 1'b1, 1'b0);
    check(acq_chan, OFFSET_CHAN);
    par_wr(1'b0, 5'h03, 1'b0, 1'b1);
    check(acq_all, 1'b1);
    par_wr(1'b1, 5'h06, 1'b0, 1'b0);
    check(n_acq, 6);
    done("parallel");
    summarize;
  end
endmodule

bind mdsp_port mdsp_port_props #(.ACQ_ALL_CYCLES(ACQ_ALL_CYCLES)) props (
  .clock(clock), .reset(reset), .frame_sel_n(frame_sel_n), .sclk(sclk),
  .dout_oe(dout_oe), .channel_addr(channel_addr), .offset_sel(offset_sel),
  .cal(cal), .acquire_mode(acquire_mode), .acq_start(acq_start),
  .acq_chan(acq_chan), .acq_all(acq_all), .acq_busy(acq_busy),
  .dac_load(dac_load));
